// file: bench/spi_host.sv
// SPI master model standing in for the controller on the serial port
`timescale 1ns/1ps
module spi_host (
  input  wire logic clk_in,
  input  wire logic miso_in,
  input  wire logic miso_oe_in,
  output logic      select_n_out,
  output logic      sck_out,
  output logic      mosi_out
);
  logic [7:0] tx [32] = '{default: 8'h00};
  logic [7:0] rx [32];
  logic       line;

  // A floating line reads high through the board pull-up
  assign line = miso_oe_in ? miso_in : 1'b1;

  initial begin
    select_n_out = 1'b1;
    sck_out = 1'b0;
    mosi_out = 1'b0;
  end

  // Sole reader of results; no second output path drains them
  // One frame of n bytes; half period of ten cycles keeps sync margin
  task automatic frame(input int n);
    @(posedge clk_in);
    select_n_out <= 1'b1;
    repeat (6) @(posedge clk_in);
    select_n_out <= 1'b0;
    repeat (8) @(posedge clk_in);
    for (int b = 0; b < n; b++) begin
      for (int k = 7; k >= 0; k--) begin
        // data set at rise, taken at fall, MSB first
        sck_out <= 1'b1;
        mosi_out <= tx[b][k];
        repeat (10) @(posedge clk_in);
        sck_out <= 1'b0;
        rx[b][k] = line;
        repeat (10) @(posedge clk_in);
      end
    end
    repeat (8) @(posedge clk_in);
    select_n_out <= 1'b1;
    mosi_out <= ~mosi_out;
  endtask : frame
endmodule : spi_host

// file: bench/tdc_spi_command_and_result_coding_tb_top.sv
// Self-checking bench for the serial command core
`timescale 1ns/1ps
module tdc_spi_command_and_result_coding_tb_top;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        ref_clk = 1'b0;
  logic [1:0]  hit_v = 2'h0;
  logic [15:0] fr_a = 16'h0000;
  logic [15:0] fr_b = 16'h0000;
  logic        sel_n, sck, mosi, miso, oe, irq_n, run, open;
  logic [7:0]  cfg [18];
  logic [15:0] fa;
  integer      seed = 77;
  integer      error_cnt = 0;
  integer      n_compared = 0;
  integer      cyc = 0;

  tdc_spi_core #(.FRAC_W(16)) u_tdc_spi_core (
    .clk_in(clk_in), .rst_in(rst_in), .select_n_in(sel_n), .sck_in(sck),
    .mosi_in(mosi), .ref_clk_in(ref_clk), .hit_valid_in(hit_v),
    .hit_fraction_a_in(fr_a), .hit_fraction_b_in(fr_b), .miso_out(miso),
    .miso_oe_out(oe), .irq_n_out(irq_n), .running_out(run),
    .stops_open_out(open));

  spi_host u_spi_host (
    .clk_in(clk_in), .miso_in(miso), .miso_oe_in(oe),
    .select_n_out(sel_n), .sck_out(sck), .mosi_out(mosi));

  always #2.5 clk_in = ~clk_in;

  // Reference period of ten cycles (50 ns); the counter also cuts hangs
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc % 5 == 4) ref_clk <= ~ref_clk;
    if (cyc == 60000) begin
      error_cnt = error_cnt + 1;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic [23:0] seen, input logic [23:0] exp,
                       input string what);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s seen %h expected %h",
               $time, what, seen, exp);
    end
  endtask : check

  function automatic logic [23:0] got3(input int k);
    return {u_spi_host.rx[k], u_spi_host.rx[k+1], u_spi_host.rx[k+2]};
  endfunction : got3

  // Divider 50000 gives a 1 ps step at this reference period
  function automatic logic [19:0] stop(input logic [15:0] f);
    logic [39:0] p;
    p = f * 24'h00C350;
    return p[35:16];
  endfunction : stop

  task automatic access(input logic [7:0] opc, input int n);
    u_spi_host.tx[0] = opc;
    u_spi_host.frame(n + 1);
  endtask : access

  task automatic rd(input logic [7:0] opc, input int n);
    for (int k = 1; k <= n; k++) u_spi_host.tx[k] = 8'h00;
    access(opc, n);
  endtask : rd

  task automatic read_cfg(input int s, input int n);
    rd(8'h40 + 8'(s), n);
    for (int k = 0; k < n; k++)
      check(24'(u_spi_host.rx[k+1]), (s+k < 18) ? 24'(cfg[s+k]) : 24'h0,
            "cfg");
  endtask : read_cfg

  task automatic wait_open();
    repeat (40) @(posedge clk_in);
    for (int k = 0; k < 400 && open !== 1'b1; k++) @(posedge clk_in);
    check(24'(open), 24'h1, "open");
  endtask : wait_open

  task automatic hit(input logic [1:0] ch, input logic [15:0] a,
                     input logic [15:0] b);
    @(posedge clk_in);
    hit_v <= ch;
    fr_a <= a;
    fr_b <= b;
    @(posedge clk_in);
    hit_v <= 2'h0;
    repeat (6) @(posedge clk_in);
  endtask : hit

  initial begin
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    check(24'(run), 24'h0, "run");
    check(24'(irq_n), 24'h1, "irq");
    $display("test reset done");
    // Power reset, then every byte reads its default, one past the end
    access(8'h30, 2);
    for (int k = 0; k < 18; k++) cfg[k] = tdc_spi_pkg::CFG_DEFAULTS[k];
    read_cfg(0, 19);
    // Full load from address zero, spare byte at 18 must be dropped
    for (int k = 1; k < 20; k++) u_spi_host.tx[k] = 8'($random(seed));
    u_spi_host.tx[1] = 8'h03;
    // 1 ps divider; fits the 20-bit result
    u_spi_host.tx[7] = 8'h50;
    u_spi_host.tx[8] = 8'hC3;
    u_spi_host.tx[9] = 8'h00;
    for (int k = 0; k < 18; k++) cfg[k] = u_spi_host.tx[k+1];
    access(8'h80, 19);
    // Undefined opcodes carrying data bytes
    access(8'hA3, 2);
    access(8'hE0, 2);
    access(8'h01, 2);
    read_cfg(0, 19);
    $display("test config done");
    access(8'h18, 0);
    repeat (8) @(posedge clk_in);
    check(24'(open), 24'h0, "early");
    check(24'(run), 24'h1, "run");
    wait_open();
    read_cfg(4, 8);
    $display("test init done");
    // Random fraction on A, full-scale fraction on B
    fa = 16'($random(seed));
    hit(2'h3, fa, 16'hFFFF);
    check(24'(irq_n), 24'h0, "irq");
    rd(8'h6B, 9);
    check(got3(1), {4'h0, stop(fa)}, "stop a");
    check(got3(7), 24'h00C34F, "stop b");
    check(24'(irq_n), 24'h1, "irq");
    rd(8'h68, 12);
    for (int k = 1; k <= 12; k++)
      check(24'(u_spi_host.rx[k]), 24'hFF, "empty");
    $display("test results done");
    // Stored result survives a restart
    fa = 16'($random(seed));
    hit(2'h1, fa, 16'h0000);
    access(8'h18, 0);
    wait_open();
    rd(8'h6B, 3);
    check(got3(1), {4'h0, stop(fa)}, "kept");
    access(8'h30, 0);
    repeat (8) @(posedge clk_in);
    check(24'(run), 24'h0, "run");
    check(24'(open), 24'h0, "open");
    rd(8'h46, 3);
    check(got3(1), 24'h90D003, "div");
    $display("test power done");
    wrap_up();
  end
endmodule : tdc_spi_command_and_result_coding_tb_top

// file: bench/tdc_spi_core_sva.sv
// Assertion checker for the serial command core
`timescale 1ns/1ps
module tdc_spi_core_sva #(
  parameter int unsigned FRAC_W = 16
) (
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic       select_n_in,
  input wire logic       sck_in,
  input wire logic       ref_clk_in,
  input wire logic [1:0] hit_valid_in,
  input wire logic       miso_out,
  input wire logic       miso_oe_out,
  input wire logic       irq_n_out,
  input wire logic       running_out,
  input wire logic       stops_open_out
);
  logic       ref_q;
  logic [4:0] ref_cnt_q;
  logic [3:0] sel_low_q;

  // Cycles selected in a row; keeps the miso check clear of select edges
  always_ff @(posedge clk_in) begin
    if (rst_in || select_n_in) begin
      sel_low_q <= 4'h0;
    end else if (sel_low_q != 4'hF) begin
      sel_low_q <= sel_low_q + 4'h1;
    end
  end

  // Raw pin rises since stops closed; leads the synced count, may miss one
  always_ff @(posedge clk_in) begin
    ref_q <= ref_clk_in;
    if (rst_in || $fell(stops_open_out) || !running_out) begin
      ref_cnt_q <= 5'h00;
    end else if (ref_clk_in && !ref_q && ref_cnt_q != 5'h1F) begin
      ref_cnt_q <= ref_cnt_q + 5'h01;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_oe_float: assert property (select_n_in [*5] |-> !miso_oe_out)
    else $error("miso driven while deselected");
  a_oe_drive: assert property (!select_n_in [*6] |-> miso_oe_out)
    else $error("miso not driven while selected");
  a_miso_edge: assert property (
    !select_n_in && sel_low_q >= 4'hB && $changed(miso_out) |-> sck_in)
    else $error("miso changed outside serial clock high phase");
  a_reset_quiet: assert property ($fell(rst_in) |->
    !running_out && !stops_open_out && irq_n_out && !miso_oe_out)
    else $error("outputs not idle after reset");
  a_stops_need_run: assert property (
    stops_open_out |-> running_out || $past(running_out))
    else $error("stops open without measurement");
  a_stops_delay: assert property (
    $rose(stops_open_out) |-> ref_cnt_q >= 5'h0F)
    else $error("stops opened before sixteen reference rises");
  a_stops_late: assert property (
    running_out && ref_cnt_q >= 5'h13 && !$fell(stops_open_out)
    |-> stops_open_out)
    else $error("stops still closed long after init");
  a_irq_on_hit: assert property (
    (|hit_valid_in) && stops_open_out |-> ##[1:4] !irq_n_out)
    else $error("interrupt not raised after a hit");
endmodule : tdc_spi_core_sva

bind tdc_spi_core tdc_spi_core_sva #(.FRAC_W(FRAC_W)) u_tdc_spi_core_sva (
  .clk_in(clk_in), .rst_in(rst_in), .select_n_in(select_n_in),
  .sck_in(sck_in), .ref_clk_in(ref_clk_in), .hit_valid_in(hit_valid_in),
  .miso_out(miso_out), .miso_oe_out(miso_oe_out), .irq_n_out(irq_n_out),
  .running_out(running_out), .stops_open_out(stops_open_out));

// file: design/cfg_regs.sv
// Configuration byte store with registered read port
`timescale 1ns/1ps
module cfg_regs (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       load_defaults_in,
  input  wire logic       wr_en_in,
  input  wire logic [4:0] wr_addr_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic [4:0] rd_addr_in,
  output logic      [7:0] rd_data_out,
  output logic      [7:0] enable_byte_out,
  output logic     [23:0] divider_out
);

  logic [tdc_spi_pkg::CFG_DEPTH-1:0][7:0] mem_q;

  // Storage; defaults come back on reset and on power opcode
  always_ff @(posedge clk_in) begin
    if (rst_in || load_defaults_in) begin
      mem_q <= tdc_spi_pkg::CFG_DEFAULTS;
    end else if (wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
  end

  // Registered read; out-of-range addresses read zero
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_data_out <= 8'h00;
    end else if (rd_addr_in <= tdc_spi_pkg::CFG_LAST_ADDR) begin
      rd_data_out <= mem_q[rd_addr_in];
    end else begin
      rd_data_out <= 8'h00;
    end
  end

  // Fields that steer the measurement logic
  assign enable_byte_out = mem_q[tdc_spi_pkg::CFG_ENA_ADDR];
  assign divider_out     = {mem_q[tdc_spi_pkg::CFG_DIV_ADDR + 5'h02],
                            mem_q[tdc_spi_pkg::CFG_DIV_ADDR + 5'h01],
                            mem_q[tdc_spi_pkg::CFG_DIV_ADDR]};

endmodule : cfg_regs

// file: design/stop_result_coder.sv
// Scales a raw fraction of the reference period into divider LSBs
`timescale 1ns/1ps
module stop_result_coder #(
  parameter int unsigned FRAC_W = 16
) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              valid_in,
  input  wire logic [FRAC_W-1:0] fraction_in,
  input  wire logic       [23:0] divider_in,
  output logic                   valid_out,
  output logic            [19:0] stop_out
);

  logic [FRAC_W+23:0] product;
  logic [23:0]        scaled;

  // Fraction is below one, so the scaled value never reaches the divider
  assign product = {24'h000000, fraction_in} * {{FRAC_W{1'b0}}, divider_in};
  assign scaled  = product[FRAC_W+23:FRAC_W];

  // [R18] LSB count
  // [R19] Top value divider-1 only while divider <= 2^FRAC_W, else divider - ceil(divider/2^FRAC_W); [R21] clamp to 20 bits
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      valid_out <= 1'b0;
      stop_out  <= 20'h00000;
    end else begin
      valid_out <= valid_in;
      if (scaled[23:20] != 4'h0) begin
        stop_out <= tdc_spi_pkg::STOP_MAX;
      end else begin
        stop_out <= scaled[19:0];
      end
    end
  end

endmodule : stop_result_coder

// file: design/tdc_spi_core.sv
// Serial command interface, measurement control and result holding
`timescale 1ns/1ps
module tdc_spi_core #(
  parameter int unsigned FRAC_W = 16
) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              select_n_in,
  input  wire logic              sck_in,
  input  wire logic              mosi_in,
  input  wire logic              ref_clk_in,
  input  wire logic        [1:0] hit_valid_in,
  input  wire logic [FRAC_W-1:0] hit_fraction_a_in,
  input  wire logic [FRAC_W-1:0] hit_fraction_b_in,
  output logic                   miso_out,
  output logic                   miso_oe_out,
  output logic                   irq_n_out,
  output logic                   running_out,
  output logic                   stops_open_out
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0] sck_sync_q;
  logic [1:0] mosi_sync_q;
  logic [1:0] sel_sync_q;
  logic [2:0] ref_sync_q;

  // Two stages before use; third stage only feeds edge detection
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sck_sync_q  <= 3'h0;
      mosi_sync_q <= 2'h0;
      sel_sync_q  <= 2'h3;
      ref_sync_q  <= 3'h0;
    end else begin
      sck_sync_q  <= {sck_sync_q[1:0], sck_in};
      mosi_sync_q <= {mosi_sync_q[0], mosi_in};
      sel_sync_q  <= {sel_sync_q[0], select_n_in};
      ref_sync_q  <= {ref_sync_q[1:0], ref_clk_in};
    end
  end

  logic sel_hi;
  logic mosi_s;
  logic sck_fall;
  logic sck_rise;
  logic ref_rise;

  assign sel_hi   = sel_sync_q[1];
  assign mosi_s   = mosi_sync_q[1];
  // [R24] Falling edge takes data
  assign sck_fall = sck_sync_q[2] & ~sck_sync_q[1];
  // [R25] Rising edge drives data
  assign sck_rise = ~sck_sync_q[2] & sck_sync_q[1];
  assign ref_rise = ~ref_sync_q[2] & ref_sync_q[1];

  // ****************************************************************
  // Serial receive and command decode
  // ****************************************************************
  tdc_spi_pkg::spi_state_e state_q;
  logic [2:0] bit_cnt_q;
  logic [6:0] rx_q;
  logic [4:0] addr_q;
  logic [7:0] rx_full;
  logic       byte_done;
  logic       opc_byte;

  assign rx_full   = {rx_q, mosi_s};
  assign byte_done = sck_fall && (bit_cnt_q == 3'h7) && !sel_hi;
  assign opc_byte  = byte_done && (state_q == tdc_spi_pkg::ST_OPCODE);

  // [R23] Select high holds the serial logic in reset
  // [R28] Each frame starts again at the opcode byte
  always_ff @(posedge clk_in) begin
    if (rst_in || sel_hi) begin
      state_q   <= tdc_spi_pkg::ST_OPCODE;
      bit_cnt_q <= 3'h0;
      rx_q      <= 7'h00;
      addr_q    <= 5'h00;
    end else if (sck_fall) begin
      rx_q      <= rx_full[6:0];
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (bit_cnt_q == 3'h7) begin
        case (state_q)
          tdc_spi_pkg::ST_OPCODE: begin
            // [R08] Start address in low five bits
            addr_q <= rx_full[4:0];
            // [R07] Write pattern
            if (rx_full[7:5] == tdc_spi_pkg::OPC_WRITE_CFG) begin
              state_q <= tdc_spi_pkg::ST_WRITE;
            // [R11] Result read pattern
            end else if (rx_full[7:5] == tdc_spi_pkg::OPC_READ_RES) begin
              state_q <= tdc_spi_pkg::ST_READ_RES;
            // [R12] Configuration read pattern
            end else if (rx_full[7:5] == tdc_spi_pkg::OPC_READ_CFG) begin
              state_q <= tdc_spi_pkg::ST_READ_CFG;
            // [R27] Power, init and unknown bytes end the frame
            end else begin
              state_q <= tdc_spi_pkg::ST_IGNORE;
            end
          end
          tdc_spi_pkg::ST_WRITE,
          tdc_spi_pkg::ST_READ_CFG,
          tdc_spi_pkg::ST_READ_RES: begin
            // [R09] Auto increment
            // [R13] Auto increment on read
            addr_q <= addr_q + 5'h01;
          end
          default: begin
            addr_q <= addr_q;
          end
        endcase
      end
    end
  end

  logic power_q;
  logic init_q;

  // Command pulses; the whole byte must match, so 0x30/0x18 only
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      power_q <= 1'b0;
      init_q  <= 1'b0;
    end else begin
      // [R01] Power opcode
      power_q <= opc_byte && (rx_full == tdc_spi_pkg::OPC_POWER);
      // [R03] Init opcode
      init_q  <= opc_byte && (rx_full == tdc_spi_pkg::OPC_INIT);
    end
  end

  // ****************************************************************
  // Configuration store
  // ****************************************************************
  logic        cfg_we;
  logic [7:0]  cfg_rd;
  logic [7:0]  enable_byte;
  logic [23:0] divider;

  // [R07] Writes past the configuration range are dropped
  assign cfg_we = byte_done && (state_q == tdc_spi_pkg::ST_WRITE) &&
                  (addr_q <= tdc_spi_pkg::CFG_LAST_ADDR);

  // [R02] Power opcode reloads defaults
  cfg_regs u_cfg (
    .clk_in           (clk_in),
    .rst_in           (rst_in),
    .load_defaults_in (power_q),
    .wr_en_in         (cfg_we),
    .wr_addr_in       (addr_q),
    .wr_data_in       (rx_full),
    .rd_addr_in       (addr_q),
    .rd_data_out      (cfg_rd),
    .enable_byte_out  (enable_byte),
    .divider_out      (divider)
  );

  // ****************************************************************
  // Measurement control
  // ****************************************************************
  localparam int unsigned REF_W_L = tdc_spi_pkg::REF_W - 1;
  logic             running_q;
  logic             open_q;
  logic [4:0]       open_cnt_q;
  logic [REF_W_L:0] ref_idx_q;

  // Init keeps stored results; power and reset clear them, as does reading a channel's last byte
  always_ff @(posedge clk_in) begin
    if (rst_in || power_q) begin
      // [R02] Measurement stopped
      running_q  <= 1'b0;
      open_q     <= 1'b0;
      open_cnt_q <= 5'h00;
      ref_idx_q  <= '0;
    end else if (init_q) begin
      // [R03] Start measuring
      running_q  <= 1'b1;
      open_q     <= 1'b0;
      open_cnt_q <= 5'h00;
      ref_idx_q  <= '0;
    end else if (running_q && ref_rise) begin
      ref_idx_q <= ref_idx_q + 1'b1;
      // [R04] Open after sixteen reference pulses
      if (!open_q) begin
        open_cnt_q <= open_cnt_q + 5'h01;
        if (open_cnt_q == tdc_spi_pkg::OPEN_PULSES - 5'h01) begin
          open_q <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Per-channel result holding
  // ****************************************************************
  logic [1:0]        ch_valid_q;
  logic [1:0][47:0]  ch_bytes;
  logic [1:0][4:0]   ch_base;
  logic [1:0]        consume;
  logic [FRAC_W-1:0] frac_in [2];

  assign frac_in[0] = hit_fraction_a_in;
  assign frac_in[1] = hit_fraction_b_in;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      logic        hit_ok;
      logic        coded_valid;
      logic [19:0] coded_stop;
      logic [23:0] ref_pipe_q;
      logic [23:0] ref_q;
      logic [19:0] stop_q;

      assign ch_base[ch] = tdc_spi_pkg::RES_FIRST +
                           5'(ch) * tdc_spi_pkg::RES_BYTES;
      // Hits count only while open and enabled by configuration
      assign hit_ok = hit_valid_in[ch] && open_q && enable_byte[ch];
      // Reading the channel's last byte frees the slot
      assign consume[ch] = sck_rise && !sel_hi && (bit_cnt_q == 3'h0) &&
                           (state_q == tdc_spi_pkg::ST_READ_RES) &&
                           (addr_q == ch_base[ch] +
                            tdc_spi_pkg::RES_BYTES - 5'h01);

      stop_result_coder #(
        .FRAC_W (FRAC_W)
      ) u_coder (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .valid_in    (hit_ok),
        .fraction_in (frac_in[ch]),
        .divider_in  (divider),
        .valid_out   (coded_valid),
        .stop_out    (coded_stop)
      );

      // Index travels alongside the coder latency
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          ref_pipe_q <= 24'h000000;
        end else if (hit_ok) begin
          ref_pipe_q <= ref_idx_q;
        end
      end

      // [R05] Results survive init
      // A new result in the consume cycle wins over the clear
      always_ff @(posedge clk_in) begin
        if (rst_in || power_q) begin
          ch_valid_q[ch] <= 1'b0;
          ref_q          <= 24'h000000;
          stop_q         <= 20'h00000;
        end else if (coded_valid) begin
          ch_valid_q[ch] <= 1'b1;
          ref_q          <= ref_pipe_q;
          stop_q         <= coded_stop;
        end else if (consume[ch]) begin
          ch_valid_q[ch] <= 1'b0;
        end
      end

      // [R15] Empty channel reads all ones
      // [R17] Fixed three-byte fields; [R21] top nibble zero
      assign ch_bytes[ch] = ch_valid_q[ch] ?
                            {ref_q, 4'h0, stop_q} :
                            {tdc_spi_pkg::EMPTY_FIELD,
                             tdc_spi_pkg::EMPTY_FIELD};
    end
  endgenerate

  // ****************************************************************
  // Read data selection and serial transmit
  // ****************************************************************
  logic [7:0] res_byte;
  logic [4:0] rel;

  // [R11] Result window; status bytes outside the channels read zero
  always_comb begin
    res_byte = 8'h00;
    rel      = 5'h00;
    for (int i = 0; i < 2; i++) begin
      if (addr_q >= ch_base[i] &&
          addr_q < ch_base[i] + tdc_spi_pkg::RES_BYTES) begin
        rel      = addr_q - ch_base[i];
        res_byte = ch_bytes[i][8'd47 - {rel, 3'h0} -: 8];
      end
    end
  end

  logic [7:0] tx_byte_q;
  logic [7:0] tx_q;
  logic       miso_q;
  logic       miso_oe_q;

  // Byte to send is staged ahead; serial clock must be much slower
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tx_byte_q <= 8'h00;
    end else if (state_q == tdc_spi_pkg::ST_READ_CFG) begin
      tx_byte_q <= cfg_rd;
    end else begin
      tx_byte_q <= res_byte;
    end
  end

  // [R23] Output floats while select is high
  // [R25] Shift out MSB first on rising edge
  always_ff @(posedge clk_in) begin
    if (rst_in || sel_hi) begin
      tx_q      <= 8'h00;
      miso_q    <= 1'b0;
      miso_oe_q <= 1'b0;
    end else begin
      miso_oe_q <= 1'b1;
      if (sck_rise && (state_q == tdc_spi_pkg::ST_READ_CFG ||
                       state_q == tdc_spi_pkg::ST_READ_RES)) begin
        if (bit_cnt_q == 3'h0) begin
          miso_q <= tx_byte_q[7];
          tx_q   <= {tx_byte_q[6:0], 1'b0};
        end else begin
          miso_q <= tx_q[7];
          tx_q   <= {tx_q[6:0], 1'b0};
        end
      end
    end
  end

  // ****************************************************************
  // Status outputs
  // ****************************************************************
  logic irq_n_q;

  // [R26] Low while any result waits
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= ~|ch_valid_q;
    end
  end

  assign miso_out       = miso_q;
  assign miso_oe_out    = miso_oe_q;
  assign irq_n_out      = irq_n_q;
  assign running_out    = running_q;
  assign stops_open_out = open_q;

endmodule : tdc_spi_core

// file: design/tdc_spi_pkg.sv
// Constants, encodings and defaults shared by the serial command block
// Functional notes
// [R01] Power opcode 0x30 does a full reset and halts measurement.
// [R02] After that reset measurement is stopped, configuration back to defaults.
// [R03] Init opcode 0x18 restarts, keeps configuration, then starts measuring.
// [R04] After init the stop channels open only after sixteen reference pulses.
// [R05] Init during measurement keeps results already stored.
// [R06] Master waits the reset recovery delay after init before next access.
// [R07] Writes reach configuration registers only; opcode top bits 100.
// [R08] Low five opcode bits hold the start register address.
// [R09] Each written data byte goes to the next higher register.
// [R10] A full configuration normally starts at address zero, all bytes in order.
// [R11] Result read opcode top bits 011 selects addresses eight to thirty-one.
// [R12] Configuration read opcode top bits 010 selects addresses zero to seventeen.
// [R13] Read shifts out bytes, advancing the address per byte, any start.
// [R14] Every access opens with its opcode right after a select pulse.
// [R15] An empty channel reads all ones in index and result fields.
// [R16] System suppresses the LVDS result path while reading over serial.
// [R17] Serial readout ignores configured LVDS field widths.
// [R18] Stop result counts LSBs of reference period over divider.
// [R19] Largest stop result is the divider minus one; the code gives divider - ceil(divider/2^FRAC_W) above 2^FRAC_W.
// [R20] For LVDS the divider must fit the configured result width.
// [R21] Serial stop result is at most 20 bits; top four bits unused.
// [R22] Divider is best set to reference period in picoseconds.
// [R23] Select high resets serial logic and floats data output.
// [R24] Input data taken on falling serial clock, MSB first.
// [R25] Output data driven on rising serial clock, MSB first.
// [R26] Interrupt output low while any result waits for readout.
// [R27] Unknown opcodes are ignored and change no register.
// [R28] Select high ends a transaction; next one starts with an opcode.
package tdc_spi_pkg;

  // ****************************************************************
  // Opcodes
  // ****************************************************************
  localparam logic [7:0] OPC_POWER     = 8'h30;
  localparam logic [7:0] OPC_INIT      = 8'h18;
  localparam logic [2:0] OPC_WRITE_CFG = 3'h4;
  localparam logic [2:0] OPC_READ_RES  = 3'h3;
  localparam logic [2:0] OPC_READ_CFG  = 3'h2;

  // ****************************************************************
  // Address map
  // ****************************************************************
  localparam logic [4:0] CFG_LAST_ADDR = 5'h11;
  localparam logic [4:0] RES_FIRST     = 5'h08;
  localparam logic [4:0] RES_BYTES     = 5'h06;
  localparam int unsigned CFG_DEPTH    = 18;
  localparam logic [4:0] CFG_ENA_ADDR  = 5'h00;
  localparam logic [4:0] CFG_DIV_ADDR  = 5'h06;

  // ****************************************************************
  // Result coding and timing
  // ****************************************************************
  localparam logic [23:0] EMPTY_FIELD   = 24'hFFFFFF;
  localparam int unsigned STOP_W        = 20;
  localparam int unsigned REF_W         = 24;
  localparam logic [19:0] STOP_MAX      = 20'hFFFFF;
  localparam logic [4:0]  OPEN_PULSES   = 5'h10;

  // Configuration defaults: both channels enabled, divider 250000
  localparam logic [CFG_DEPTH-1:0][7:0] CFG_DEFAULTS = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h03, 8'hD0, 8'h90, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03};

  typedef enum logic [2:0] {
    ST_OPCODE   = 3'b000,
    ST_WRITE    = 3'b001,
    ST_READ_CFG = 3'b010,
    ST_READ_RES = 3'b011,
    ST_IGNORE   = 3'b100
  } spi_state_e;

endpackage : tdc_spi_pkg
